// File: inc/spi_fault_pkg.sv
package spi_fault_pkg;
  // --------------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] DATA_ADDR   = 4'h8;
  // control register fields
  localparam int CTRL_RXIE_BIT = 0;
  localparam int CTRL_MASTER_SELECT_ALT_BIT = 1;
  localparam int CTRL_CPOL_BIT = 2;
  localparam int CTRL_CPHA_BIT = 3;
  localparam int CTRL_TXIE_BIT = 4;
  localparam int CTRL_PE_BIT   = 5;
  localparam logic [5:0] CTRL_RESET = 6'h0a;
  // status and control register fields
  localparam int STAT_RXF_BIT    = 0;
  localparam int STAT_ERROR_IRQ_ENABLE_BIT  = 1;
  localparam int STAT_OVR_BIT    = 2;
  localparam int STAT_MODE_FAULT_FLAG_BIT   = 3;
  localparam int STAT_MODE_FAULT_ENABLE_BIT = 4;
  localparam int STAT_TXE_BIT    = 5;
  localparam int STAT_RATE_LSB   = 6;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // --------------------------------------------------------------------
  // serial timing
  // --------------------------------------------------------------------
  localparam logic [3:0] LAST_EDGE      = 4'hf;
  localparam logic [2:0] OVR_SAMPLE_IDX = 3'h6;
  // --------------------------------------------------------------------
  // bus responses and engine states
  // --------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_RUN} engState_t;
endpackage

// File: design/spi_fault_irq.sv
// Behaviour
// - master select drives clock and master-out; slave reverses directions
// - fault: slave select rises mid-transfer, or select input goes low while master select is set
// - fault flag sets only with fault enable; disabling keeps current flag
// - master fault clears enable, sets tx empty, clears counter, frees pins
// - phase 0 slave: transfer from select fall to clock idle after bit 8
// - phase 1 slave: transfer from first clock edge with select low
// - phase 0 select/deselect without clock faults; phase 1 does not
// - fault leaves master select unchanged; master select inert when disabled
// - slave fault raises error request only, port stays enabled
// - deselected slave floats master-in and ignores all clock edges
// - fault flag clears by status read then control write, unless fault persists
// - tx empty requests interrupt only with tx enable and port enable
// - rx full requests interrupt with its enable regardless of port enable
// - one error enable gates both overrun and fault flags
// - rx full clears by status read seeing it, then data read
// - only a data register write clears tx empty
// - byte into receive register sets rx full; byte into shifter sets tx empty
// - disabled port holds tx empty, aborts, clears shifter and counter
// - controls and flags other than tx empty survive disable; disabling clears none of them
// - port keeps running in wait mode; enabled requests wake the cpu
// - overrun blocks rx full; clears by status read then data read
// - overrun sets at bit 1 capture when receive data unread; byte dropped
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spi_fault_irq
  import spi_fault_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // axi4-lite write channels
  input  wire logic [3:0] awaddr,
  input  wire logic       awvalid,
  output var  logic       awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output var  logic       wready,
  output var  logic [1:0] bresp,
  output var  logic       bvalid,
  input  wire logic       bready,
  // axi4-lite read channels
  input  wire logic [3:0] araddr,
  input  wire logic       arvalid,
  output var  logic       arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0] rresp,
  output var  logic       rvalid,
  input  wire logic       rready,
  // serial pins, output enables active low
  input  wire logic       sckIn,
  output var  logic       sckOut,
  output var  logic       sckOe_n,
  input  wire logic       mosiIn,
  output var  logic       mosiOut,
  output var  logic       mosiOe_n,
  input  wire logic       misoIn,
  output var  logic       misoOut,
  output var  logic       misoOe_n,
  input  wire logic       selectIn_n,
  // requests and pin ownership
  output var  logic       txIrq,
  output var  logic       rxErrIrq,
  output var  logic       wakeReq,
  output var  logic       gpioOwnsPins
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic       rxIrqEnable, masterSelect, cpol, cpha, txIrqEnable, portEnable;
  logic       errIrqEnable, modeFaultEnable;
  logic [1:0] rateSelect;
  logic       rxFullFlag, overrunFlag, modeFaultFlag, txEmptyFlag;
  logic       armRx, armOvr, armModf;
  logic [7:0] txData, rxData, shTx, shRx;
  logic [3:0] edgeCnt;
  logic [6:0] halfCnt;
  logic       discard, txLoad, rxDone, ovrHit;
  engState_t  state;
  logic       sckM, sckS, sckPrev, mosiM, mosiS, misoM, misoS, ssM, ssS, ssPrev;
  logic [3:0] wrAddr;

  // half serial-clock period in bus cycles for each rate select
  function automatic logic [6:0] halfCycles(input logic [1:0] rate);
    case (rate)
      2'h0:    halfCycles = 7'h01;
      2'h1:    halfCycles = 7'h04;
      2'h2:    halfCycles = 7'h10;
      default: halfCycles = 7'h40;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  logic wrHs, arHs, ctrlWrite, dataWrite, statusRead, dataRead;
  assign wrHs       = awready & awvalid & wvalid;
  assign arHs       = arready & arvalid;
  assign ctrlWrite  = wrHs & (awaddr == CTRL_ADDR) & wstrb[0];
  assign dataWrite  = wrHs & (awaddr == DATA_ADDR) & wstrb[0];
  assign statusRead = arHs & (araddr == STATUS_ADDR);
  assign dataRead   = arHs & (araddr == DATA_ADDR);

  // fault detection and edge classification
  logic masterFault, slaveFault, sckEdge, ssFall, edgeNow, isSample, inBit;
  assign masterFault = portEnable & masterSelect & modeFaultEnable & ~ssS;
  assign slaveFault  = portEnable & ~masterSelect & modeFaultEnable
                       & (state == ST_RUN) & ssS;
  assign sckEdge  = sckS ^ sckPrev;
  assign ssFall   = ssPrev & ~ssS;
  assign edgeNow  = masterSelect ? (state == ST_RUN && halfCnt == 7'h00)
                  : (sckEdge & ~ssS & (state == ST_RUN | cpha));
  assign isSample = (edgeCnt[0] == cpha);
  assign inBit    = masterSelect ? misoS : mosiS;

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    sckM    <= sckIn;
    sckS    <= sckM;
    sckPrev <= sckS;
    mosiM   <= mosiIn;
    mosiS   <= mosiM;
    misoM   <= misoIn;
    misoS   <= misoM;
    ssM     <= selectIn_n;
    ssS     <= ssM;
    ssPrev  <= ssS;
  end

  // --------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------
  // write: both channels taken together, answer one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wrAddr  <= 4'h0;
    end else begin
      awready <= awvalid & wvalid & ~awready & ~bvalid;
      wready  <= awvalid & wvalid & ~awready & ~bvalid;
      if (wrHs) begin
        bvalid <= 1'b1;
        wrAddr <= awaddr;
        bresp  <= (awaddr == CTRL_ADDR || awaddr == STATUS_ADDR || awaddr == DATA_ADDR)
                  ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read: data captured on the address handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arHs) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        rdata  <= 32'h0;
        unique case (araddr)
          CTRL_ADDR:   rdata[5:0] <= {portEnable, txIrqEnable, cpha, cpol,
                                      masterSelect, rxIrqEnable};
          STATUS_ADDR: rdata[7:0] <= {rateSelect, txEmptyFlag, modeFaultEnable,
                                      modeFaultFlag, overrunFlag, errIrqEnable, rxFullFlag};
          DATA_ADDR:   rdata[7:0] <= rxData;
          default:     rresp      <= RESP_SLVERR;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // control bits, kept through disable
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      {portEnable, txIrqEnable, cpha, cpol, masterSelect, rxIrqEnable} <= CTRL_RESET;
      errIrqEnable    <= 1'b0;
      modeFaultEnable <= 1'b0;
      rateSelect      <= RATE_RESET;
    end else begin
      if (ctrlWrite) begin
        rxIrqEnable  <= wdata[CTRL_RXIE_BIT];
        masterSelect <= wdata[CTRL_MASTER_SELECT_ALT_BIT];
        cpol         <= wdata[CTRL_CPOL_BIT];
        cpha         <= wdata[CTRL_CPHA_BIT];
        txIrqEnable  <= wdata[CTRL_TXIE_BIT];
        portEnable   <= wdata[CTRL_PE_BIT];
      end
      if (wrHs && awaddr == STATUS_ADDR && wstrb[0]) begin
        errIrqEnable    <= wdata[STAT_ERROR_IRQ_ENABLE_BIT];
        modeFaultEnable <= wdata[STAT_MODE_FAULT_ENABLE_BIT];
        rateSelect      <= wdata[STAT_RATE_LSB +: 2];
      end
      // master fault drops the enable but not master select
      if (masterFault) portEnable <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // shift engine
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    txLoad <= 1'b0;
    rxDone <= 1'b0;
    ovrHit <= 1'b0;
    if (rst || !portEnable || masterFault) begin
      // abort, clear shifter and bit counter
      state   <= ST_IDLE;
      edgeCnt <= 4'h0;
      shTx    <= 8'h00;
      shRx    <= 8'h00;
      halfCnt <= 7'h00;
      discard <= 1'b0;
      sckOut  <= rst ? 1'b0 : cpol;
    end else begin
      if (masterSelect) begin
        if (state == ST_IDLE) begin
          sckOut <= cpol;
          if (!txEmptyFlag) begin
            shTx    <= txData;
            txLoad  <= 1'b1;
            state   <= ST_RUN;
            halfCnt <= halfCycles(rateSelect) - 7'h01;
          end
        end else if (halfCnt == 7'h00) begin
          halfCnt <= halfCycles(rateSelect) - 7'h01;
          sckOut  <= ~sckOut;
        end else begin
          halfCnt <= halfCnt - 7'h01;
        end
      end else if (ssS) begin
        // deselected slave drops any partial byte
        state   <= ST_IDLE;
        edgeCnt <= 4'h0;
        discard <= 1'b0;
      end else if (state == ST_IDLE && ((!cpha && ssFall) || (cpha && sckEdge))) begin
        state <= ST_RUN;
      end
      // slave reloads its shifter only between transfers
      if (!masterSelect && state == ST_IDLE && !txEmptyFlag && !edgeNow) begin
        shTx   <= txData;
        txLoad <= 1'b1;
      end
      if (edgeNow) begin
        if (isSample) begin
          shRx <= {shRx[6:0], inBit};
          if (edgeCnt[3:1] == OVR_SAMPLE_IDX && rxFullFlag) begin
            ovrHit  <= 1'b1;
            discard <= 1'b1;
          end
        end else if (!(cpha && edgeCnt == 4'h0)) begin
          shTx <= {shTx[6:0], 1'b0};
        end
        edgeCnt <= edgeCnt + 4'h1;
        if (edgeCnt == LAST_EDGE) begin
          // clock back at idle after the eighth bit
          state   <= ST_IDLE;
          discard <= 1'b0;
          rxDone  <= ~discard & ~overrunFlag;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // status flags and clearing sequences
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rxFullFlag    <= 1'b0;
      overrunFlag   <= 1'b0;
      modeFaultFlag <= 1'b0;
      txEmptyFlag   <= 1'b1;
      armRx         <= 1'b0;
      armOvr        <= 1'b0;
      armModf       <= 1'b0;
      rxData        <= 8'h00;
      txData        <= 8'h00;
    end else begin
      // a status read arms each clear with what it saw
      if (statusRead) begin
        armRx   <= rxFullFlag;
        armOvr  <= overrunFlag;
        armModf <= modeFaultFlag;
      end else begin
        if (dataRead) armRx <= 1'b0;
        if (dataRead) armOvr <= 1'b0;
        if (ctrlWrite) armModf <= 1'b0;
      end
      if (rxDone) begin
        rxFullFlag <= 1'b1;
        rxData     <= shRx;
      end else if (dataRead && armRx) begin
        rxFullFlag <= 1'b0;
      end
      if (ovrHit) overrunFlag <= 1'b1;
      else if (dataRead && armOvr) overrunFlag <= 1'b0;
      // set wins over the clear, so a lasting fault keeps the flag
      if (masterFault || slaveFault) modeFaultFlag <= 1'b1;
      else if (ctrlWrite && armModf) modeFaultFlag <= 1'b0;
      if (dataWrite) txData <= wdata[7:0];
      if (!portEnable || txLoad || masterFault) txEmptyFlag <= 1'b1;
      else if (dataWrite) txEmptyFlag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // pins and requests
  // --------------------------------------------------------------------
  // pin direction follows master select only while enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      sckOe_n      <= 1'b1;
      mosiOe_n     <= 1'b1;
      misoOe_n     <= 1'b1;
      mosiOut      <= 1'b0;
      misoOut      <= 1'b0;
      gpioOwnsPins <= 1'b1;
    end else begin
      sckOe_n      <= ~(portEnable & masterSelect);
      mosiOe_n     <= ~(portEnable & masterSelect);
      misoOe_n     <= ~(portEnable & ~masterSelect & ~ssS);
      mosiOut      <= shTx[7];
      misoOut      <= shTx[7];
      gpioOwnsPins <= ~portEnable;
    end
  end

  // requests run in wait mode too; any one wakes the cpu
  always_ff @(posedge clk) begin
    if (rst) begin
      txIrq    <= 1'b0;
      rxErrIrq <= 1'b0;
      wakeReq  <= 1'b0;
    end else begin
      txIrq    <= txEmptyFlag & txIrqEnable & portEnable;
      rxErrIrq <= (rxFullFlag & rxIrqEnable)
                  | (errIrqEnable & (overrunFlag | modeFaultFlag));
      wakeReq  <= (txEmptyFlag & txIrqEnable & portEnable) | (rxFullFlag & rxIrqEnable)
                  | (errIrqEnable & (overrunFlag | modeFaultFlag));
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mode_fault_flag_needs_enable: assert property ($rose(modeFaultFlag) |-> $past(modeFaultEnable))
    else $error("fault flag set without fault enable");
  a_master_fault_off: assert property (masterFault |=> !portEnable && txEmptyFlag)
    else $error("master fault did not disable port");
  a_slave_fault_keep: assert property (slaveFault && !ctrlWrite |=> portEnable)
    else $error("slave fault changed port enable");
  a_mode_fault_flag_clear_seq: assert property ($fell(modeFaultFlag) |-> $past(ctrlWrite && armModf))
    else $error("fault flag cleared outside its sequence");
  a_tx_empty_clear: assert property ($fell(txEmptyFlag) |-> $past(dataWrite))
    else $error("tx empty cleared without data write");
  a_disabled_tx_hold: assert property (!portEnable |=> txEmptyFlag && state == ST_IDLE)
    else $error("disabled port not held idle");
  a_overrun_blocks: assert property ($rose(rxFullFlag) |-> !$past(overrunFlag, 2))
    else $error("rx full set while overrun pending");
  a_tx_irq_gate: assert property (txIrq |-> $past(portEnable) && $past(txIrqEnable))
    else $error("tx request without both enables");
  a_miso_float: assert property (ssS && !masterSelect |=> misoOe_n)
    else $error("deselected slave drives master-in");
  a_err_request: assert property (errIrqEnable && overrunFlag |=> rxErrIrq)
    else $error("overrun not gated onto shared request");
endmodule
`default_nettype wire

// File: test/spi_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// remote party on the serial link, slave or master by role
// ------------------------------------------------------------
module spi_far_end (
  // role and resolved wires
  input  wire logic       actMaster,
  input  wire logic       sckW,
  input  wire logic       mosiW,
  input  wire logic       misoW,
  // lines this party drives
  output var  logic       sckP,
  output var  logic       mosiP,
  output var  logic       misoP,
  output var  logic       selP_n,
  output var  logic [7:0] gotByte
);
  logic [7:0] txSh;
  logic [7:0] nextOut;
  int         bitN;
  // clock stands low outside frames, data lines at pull-up level
  initial begin
    sckP = 1'b0;
    mosiP = 1'b1;
    misoP = 1'b1;
    selP_n = 1'b1;
    gotByte = 8'h00;
    nextOut = 8'h40;
    bitN = 0;
  end
  // slave role: msb first, new bit on the leading edge
  always @(posedge sckW) if (!actMaster) begin
    if (bitN == 0) txSh = nextOut;
    misoP = txSh[7];
    txSh = {txSh[6:0], 1'b1};
  end
  // slave role: capture on the trailing edge, next byte counts up
  always @(negedge sckW) if (!actMaster) begin
    gotByte = {gotByte[6:0], mosiW};
    bitN = (bitN == 7) ? 0 : bitN + 1;
    if (bitN == 0) nextOut = nextOut + 8'h01;
  end
  // select line, set by the bench
  task automatic sel(input logic v);
    selP_n <= v;
  endtask
  // master role: one phase 1 byte at an 800 ns clock period
  task automatic xfer(input logic [7:0] b);
    #37;
    selP_n = 1'b0;
    #1000;
    for (int i = 7; i >= 0; i--) begin
      mosiP = b[i];
      sckP = 1'b1;
      #400;
      sckP = 1'b0;
      #300;
      gotByte = {gotByte[6:0], misoW};
      #100;
    end
    mosiP = 1'b1;
    #1000;
    selP_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import spi_fault_pkg::*;
();
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, actMaster;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, seenResp;
  logic        sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
  logic        txIrq, rxErrIrq, wakeReq, gpioOwnsPins, sckP, mosiP, misoP, selP_n;
  logic [7:0]  gotByte;
  int          failCount = 0;
  int          checks = 0;
  // resolved pins, released lines sit at their pull-up
  wire logic sckW = !sckOe_n ? sckOut : sckP;
  wire logic mosiW = !mosiOe_n ? mosiOut : (actMaster ? mosiP : 1'b1);
  wire logic misoW = !misoOe_n ? misoOut : (actMaster ? 1'b1 : misoP);

  spi_fault_irq dut (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sckIn(sckW), .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiW), .mosiOut(mosiOut),
    .mosiOe_n(mosiOe_n), .misoIn(misoW), .misoOut(misoOut), .misoOe_n(misoOe_n),
    .selectIn_n(selP_n), .txIrq(txIrq), .rxErrIrq(rxErrIrq), .wakeReq(wakeReq),
    .gpioOwnsPins(gpioOwnsPins)
  );
  spi_far_end far (
    .actMaster(actMaster), .sckW(sckW), .mosiW(mosiW), .misoW(misoW), .sckP(sckP),
    .mosiP(mosiP), .misoP(misoP), .selP_n(selP_n), .gotByte(gotByte)
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // hold reset for k edges, release it, then let one more edge pass
  task automatic applyReset(input int k);
    for (int i = k; i >= 0; i--) begin
      rst <= (i > 0);
      @(posedge clk);
    end
  endtask
  // bus write, address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    logic awTaken, wTaken;
    awTaken = 1'b0;
    wTaken = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awTaken && wTaken)) begin
      @(posedge clk);
      if (awready === 1'b1) awTaken = 1'b1;
      if (wready === 1'b1) wTaken = 1'b1;
      awvalid <= ~awTaken;
      wvalid <= ~wTaken;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    seenResp = bresp;
    @(posedge clk);
  endtask
  // bus read with expected data, taken at the edge where rvalid is seen
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    seenResp = rresp;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and test sequence
  // ------------------------------------------------------------
  always #50 clk = ~clk;
  initial begin
    #2000000;
    failCount++;
    giveVerdict();
  end
  initial begin
    clk = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    actMaster = 1'b1;
    applyReset(12);
    // reset values and the idle disabled port
    rd(CTRL_ADDR, 32'h0a);
    rd(STATUS_ADDR, 32'h20);
    chk(gpioOwnsPins, 1'b1);
    rd(4'hc, 32'h0);
    chk(seenResp, RESP_SLVERR);
    // write without the low byte lane, then a write to a hole
    wr(CTRL_ADDR, 8'h3a, 4'he);
    chk(seenResp, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0a);
    wr(4'hc, 8'hff);
    chk(seenResp, RESP_SLVERR);
    $display("test reset done");
    // enabled master exchanges one byte at rate 1
    actMaster <= 1'b0;
    wr(STATUS_ADDR, 8'h42);
    wr(CTRL_ADDR, 8'h3a);
    chk({sckOe_n, mosiOe_n, misoOe_n}, 3'b001);
    chk(txIrq, 1'b1);
    wr(DATA_ADDR, 8'ha5);
    cyc(90);
    chk(gotByte, 8'ha5);
    rd(STATUS_ADDR, 32'h63);
    rd(DATA_ADDR, 32'h40);
    rd(STATUS_ADDR, 32'h62);
    chk(rxErrIrq, 1'b0);
    wr(CTRL_ADDR, 8'h1a);
    chk({txIrq, gpioOwnsPins, sckOe_n}, 3'b011);
    $display("test master done");
    // unread byte, then two more: overrun keeps the first
    wr(CTRL_ADDR, 8'h3a);
    wr(DATA_ADDR, 8'h11);
    cyc(90);
    wr(DATA_ADDR, 8'h22);
    cyc(90);
    chk(rxErrIrq, 1'b1);
    rd(STATUS_ADDR, 32'h67);
    wr(DATA_ADDR, 8'h33);
    cyc(90);
    rd(DATA_ADDR, 32'h41);
    rd(STATUS_ADDR, 32'h62);
    $display("test overrun done");
    // select pulled low under an enabled master
    far.sel(1'b0);
    cyc(10);
    rd(STATUS_ADDR, 32'h62);
    rd(CTRL_ADDR, 32'h3a);
    wr(STATUS_ADDR, 8'h52);
    cyc(10);
    rd(CTRL_ADDR, 32'h1a);
    rd(STATUS_ADDR, 32'h7a);
    chk(gpioOwnsPins, 1'b1);
    chk({rxErrIrq, wakeReq}, 2'b11);
    wr(CTRL_ADDR, 8'h3a);
    cyc(10);
    rd(STATUS_ADDR, 32'h7a);
    far.sel(1'b1);
    cyc(10);
    wr(STATUS_ADDR, 8'h42);
    rd(STATUS_ADDR, 32'h6a);
    wr(CTRL_ADDR, 8'h1a);
    rd(STATUS_ADDR, 32'h62);
    $display("test master fault done");
    // phase 1 slave: bare select pulse, then a byte
    actMaster <= 1'b1;
    wr(STATUS_ADDR, 8'h52);
    wr(CTRL_ADDR, 8'h29);
    chk(misoOe_n, 1'b1);
    wr(DATA_ADDR, 8'h96);
    far.sel(1'b0);
    cyc(20);
    far.sel(1'b1);
    cyc(10);
    far.xfer(8'h5b);
    cyc(10);
    chk(gotByte, 8'h96);
    wr(CTRL_ADDR, 8'h09);
    chk(rxErrIrq, 1'b1);
    rd(STATUS_ADDR, 32'h73);
    rd(DATA_ADDR, 32'h5b);
    $display("test slave phase 1 done");
    // phase 0 slave: select pulse with no clock faults
    wr(CTRL_ADDR, 8'h21);
    far.sel(1'b0);
    cyc(20);
    chk(misoOe_n, 1'b0);
    far.sel(1'b1);
    cyc(10);
    chk(rxErrIrq, 1'b1);
    rd(CTRL_ADDR, 32'h21);
    rd(STATUS_ADDR, 32'h7a);
    $display("test slave phase 0 done");
    // system reset in mid-run clears controls and the pending fault
    applyReset(3);
    rd(CTRL_ADDR, 32'h0a);
    rd(STATUS_ADDR, 32'h20);
    $display("test second reset done");
    giveVerdict();
  end
endmodule
`default_nettype wire
